// ---- rtl/adc_pkg.sv ----
// constants, types and pin groups of the converter control and lane readout
// assumes a single 25 MHz system clock; all pins arrive asynchronously
package adc_pkg;

   localparam int RESULT_W       = 16;
   localparam int FIFO_DEPTH_DEF = 16;
   localparam int EDGES_SINGLE   = 16;
   localparam int EDGES_DUAL     = 8;

   // timing, in ns as printed, and derived cycle counts at the system clock
   localparam int CLK_PERIOD_NS  = 40;
   localparam int CONV_MIN_NS    = 54;
   localparam int CONV_MAX_NS    = 63;
   localparam int FIRST_EDGE_NS  = 65;
   localparam int LAST_EDGE_NS   = 49;
   localparam int CONV_MIN_CYC   = (CONV_MIN_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
   localparam int CONV_MAX_CYC   = (CONV_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int CONV_CYC       = CONV_MIN_CYC;
   localparam int CONV_CNT_W     = $clog2(CONV_CYC + 1);

   localparam logic [15:0] TEST_PATTERN_DEF = 16'hA53C;

   typedef enum logic [1:0] {
      ST_ACQ     = 2'b00,
      ST_CONV    = 2'b01,
      ST_HANDOFF = 2'b10
   } conv_state_e;

   typedef struct packed {
      logic sleep_request_n;
      logic fixed_output_select;
      logic dual_lane_select;
   } strap_s;

   typedef struct packed {
      logic echo_clock_out;
      logic lane_a_out;
      logic lane_b_out;
      logic lane_a_enable;
      logic lane_b_enable;
   } lane_s;

   localparam lane_s LANE_RST = 5'h00;

endpackage

// ---- rtl/adc_readout.sv ----
// successive approximation control, result buffer and serial lane readout
// assumes strap, trigger, shift clock and sample level are asynchronous pins
//
// Summary of operation
// - sleep input low stops conversion, readout and all output drivers
// - fixed output select high sends the test pattern instead of results
// - dual lane mode shifts two bits per edge, on lanes A and B
// - single lane mode shifts one bit per edge on lane A
// - single lane mode leaves lane B low with its driver disabled
// - echo clock output reproduces the sampled host shift clock
// - trigger rising edge puts sample into hold and starts conversion
// - block alternates between acquisition tracking and conversion
// - held level resolved by binary weighted trials down to 1/65536
// - finished conversion yields a 16-bit word queued for transfer
// - output words are two's complement
// - each word belongs to its own conversion, no pipeline delay
// - result ready a fixed cycle count after the trigger edge
`timescale 1ns/10ps
`default_nettype none

module adc_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         clear,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [0:DEPTH-1];
   logic [AW:0]  wr_ptr_r;
   logic [AW:0]  rd_ptr_r;
   wire          full;
   wire          empty;
   wire          push;
   wire          pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("fifo depth must be a power of two, at least 2");
   end

   assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                      (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
   assign empty     = (wr_ptr_r == rd_ptr_r);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;
   assign out_data  = mem[rd_ptr_r[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
         rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
      end
   end
endmodule

module adc_readout #(
   parameter logic [15:0] TEST_PATTERN = adc_pkg::TEST_PATTERN_DEF,
   parameter int          EDGES_1LANE  = adc_pkg::EDGES_SINGLE,
   parameter int          EDGES_2LANE  = adc_pkg::EDGES_DUAL,
   parameter int          FIFO_DEPTH   = adc_pkg::FIFO_DEPTH_DEF
) (
   // clock and reset
   input  wire logic                          CLK,
   input  wire logic                          RST,
   // static mode pins
   input  wire adc_pkg::strap_s               STRAPS,
   // conversion trigger and analog front end
   input  wire logic                          SAMPLE_TRIGGER,
   input  wire logic [adc_pkg::RESULT_W-1:0]  SAMPLE_LEVEL,
   output logic                               TRACK_HOLD,
   // serial link
   input  wire logic                          SHIFT_CLOCK,
   output adc_pkg::lane_s                     LANE
);
   import adc_pkg::*;

   localparam int EDGE_W = $clog2(EDGES_1LANE + 1);
   localparam int SYNC_W = RESULT_W + 5;

   if (EDGES_1LANE != RESULT_W || EDGES_2LANE * 2 != RESULT_W) begin
      $error("edge counts must match the word width per lane mode");
   end

   // the level word is taken bitwise; it must stand steady around each trigger
   // two-flop synchronisers for every pin
   logic [SYNC_W-1:0]      sync_1_r;
   logic [SYNC_W-1:0]      sync_2_r;
   logic                   trig_d_r;
   logic                   sclk_d_r;
   wire  strap_s           straps;
   wire                    trig_s;
   wire                    sclk_s;
   wire  [RESULT_W-1:0]    level_s;

   always_ff @(posedge CLK) begin
      if (RST) begin
         sync_1_r <= '0;
         sync_2_r <= '0;
         trig_d_r <= 1'b0;
         sclk_d_r <= 1'b0;
      end else begin
         sync_1_r <= {STRAPS, SAMPLE_TRIGGER, SHIFT_CLOCK, SAMPLE_LEVEL};
         sync_2_r <= sync_1_r;
         trig_d_r <= trig_s;
         sclk_d_r <= sclk_s;
      end
   end

   assign straps  = sync_2_r[SYNC_W-1 -: 3];
   assign trig_s  = sync_2_r[RESULT_W+1];
   assign sclk_s  = sync_2_r[RESULT_W];
   assign level_s = sync_2_r[RESULT_W-1:0];

   wire awake     = straps.sleep_request_n;
   wire dual      = straps.dual_lane_select;
   wire trig_rise = trig_s && !trig_d_r;
   wire sclk_fall = !sclk_s && sclk_d_r;

   // conversion sequencer
   conv_state_e            state_r;
   conv_state_e            state_nxt;
   logic [CONV_CNT_W-1:0]  cnt_r;
   logic [RESULT_W-1:0]    held_r;
   logic [RESULT_W-1:0]    result_r;
   logic                   hold_r;
   wire                    fifo_in_ready;

   // binary weighted trials, MSB first, one comparison per weight
   logic [RESULT_W-1:0]    sar_step [0:RESULT_W];
   assign sar_step[RESULT_W] = '0;
   for (genvar i = 0; i < RESULT_W; i++) begin : g_sar
      wire [RESULT_W-1:0] trial = sar_step[i+1] |
                                  (RESULT_W'(1) << i);
      assign sar_step[i] = (held_r >= trial) ? trial : sar_step[i+1];
   end
   // offset binary trials turned into two's complement
   wire [RESULT_W-1:0] sar_code = {~sar_step[0][RESULT_W-1],
                                   sar_step[0][RESULT_W-2:0]};

   // the word is ready the least whole cycle count past the earliest ready time
   wire conv_done = (state_r == ST_CONV) && (cnt_r == '0);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_ACQ: begin
            if (trig_rise) begin
               state_nxt = ST_CONV;
            end
         end
         ST_CONV: begin
            if (cnt_r == '0) begin
               state_nxt = ST_HANDOFF;
            end
         end
         ST_HANDOFF: begin
            if (fifo_in_ready) begin
               state_nxt = ST_ACQ;
            end
         end
         default: begin
            state_nxt = ST_ACQ;
         end
      endcase
      if (!awake) begin
         state_nxt = ST_ACQ;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_r  <= ST_ACQ;
         cnt_r    <= '0;
         held_r   <= '0;
         result_r <= '0;
         hold_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         hold_r  <= (state_nxt != ST_ACQ);
         if (state_r == ST_ACQ) begin
            cnt_r  <= CONV_CNT_W'(CONV_CYC - 1);
            held_r <= level_s;
         end else if (state_r == ST_CONV) begin
            cnt_r <= cnt_r - CONV_CNT_W'(1);
         end
         if (conv_done) begin
            result_r <= sar_code;
         end
      end
   end

   // result buffer between converter and serialiser
   wire                  fifo_out_valid;
   wire [RESULT_W-1:0]   fifo_out_data;
   wire                  load;
   logic                 active_r;

   // a full buffer keeps the sequencer in hand-off, so later triggers are lost
   assign load = awake && !active_r && fifo_out_valid;

   adc_fifo #(
      .W     (RESULT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (CLK),
      .rst       (RST),
      .clear     (!awake),
      .in_valid  (state_r == ST_HANDOFF),
      .in_ready  (fifo_in_ready),
      .in_data   (result_r),
      .out_valid (fifo_out_valid),
      .out_ready (load),
      .out_data  (fifo_out_data)
   );

   // serialiser: bit on the lanes, advanced on each falling shift edge
   logic [RESULT_W-1:0]  shift_r;
   logic [EDGE_W-1:0]    edges_r;
   logic                 dual_r;
   lane_s                lane_r;
   lane_s                lane_nxt;

   wire [RESULT_W-1:0] word = straps.fixed_output_select ?
                              TEST_PATTERN : fifo_out_data;
   // lane mode is latched per word for shift and edge count; lane B data and driver still follow the live strap
   wire [RESULT_W-1:0] shifted = dual_r ? {shift_r[RESULT_W-3:0], 2'b00}
                                        : {shift_r[RESULT_W-2:0], 1'b0};

   always_ff @(posedge CLK) begin
      if (RST || !awake) begin
         active_r <= 1'b0;
         shift_r  <= '0;
         edges_r  <= '0;
         dual_r   <= 1'b0;
      end else if (load) begin
         active_r <= 1'b1;
         shift_r  <= word;
         dual_r   <= dual;
         edges_r  <= dual ? EDGE_W'(EDGES_2LANE)
                          : EDGE_W'(EDGES_1LANE);
      end else if (active_r && sclk_fall) begin
         shift_r  <= shifted;
         edges_r  <= edges_r - EDGE_W'(1);
         active_r <= (edges_r != EDGE_W'(1));
      end
   end

   // data is gated by the synced sleep level so it never outlives its driver
   wire lane_a_bit = awake && active_r && shift_r[RESULT_W-1];
   wire lane_b_bit = awake && active_r && dual_r && dual &&
                     shift_r[RESULT_W-2];

   always_comb begin
      lane_nxt                = LANE_RST;
      lane_nxt.echo_clock_out = awake && sclk_s;
      lane_nxt.lane_a_enable  = awake;
      lane_nxt.lane_b_enable  = awake && dual;
      lane_nxt.lane_a_out     = lane_a_bit;
      lane_nxt.lane_b_out     = lane_b_bit;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         lane_r <= LANE_RST;
      end else begin
         lane_r <= lane_nxt;
      end
   end

   assign LANE       = lane_r;
   assign TRACK_HOLD = hold_r;
endmodule

`default_nettype wire

// ---- testbench/adc_readout_checker.sv ----
// checker for the converter lane readout, bound to adc_readout
// assumes straps held steady for several cycles around each change
`timescale 1ns/10ps
`default_nettype none
module adc_readout_checker
   import adc_pkg::*;
(
   // clock and reset
   input wire logic                CLK,
   input wire logic                RST,
   // pins of the block
   input wire adc_pkg::strap_s     STRAPS,
   input wire logic                SAMPLE_TRIGGER,
   input wire logic [RESULT_W-1:0] SAMPLE_LEVEL,
   input wire logic                TRACK_HOLD,
   input wire logic                SHIFT_CLOCK,
   input wire adc_pkg::lane_s      LANE
);
   logic [3:0] rcnt_r;
   logic       settled;
   logic       awake;
   assign settled = rcnt_r == 4'hF;
   assign awake   = STRAPS.sleep_request_n;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // cycles since reset release, so synchronisers have flushed
   always_ff @(posedge CLK) begin
      if (RST) begin
         rcnt_r <= 4'h0;
      end else if (!settled) begin
         rcnt_r <= rcnt_r + 4'h1;
      end
   end
   chk_sleep_quiet: assert property (settled && !awake
      && !$past(awake, 5) |-> LANE == LANE_RST && !TRACK_HOLD)
      else $error("block active while asleep");
   chk_awake_lane_a: assert property (settled && awake
      && $past(awake, 5) |-> LANE.lane_a_enable)
      else $error("lane a driver off while awake");
   chk_single_b_off: assert property (settled
      && !STRAPS.dual_lane_select && !$past(STRAPS.dual_lane_select, 5)
      |-> !LANE.lane_b_enable && !LANE.lane_b_out)
      else $error("lane b active in single lane mode");
   chk_dual_b_on: assert property (settled && awake && $past(awake, 5)
      && STRAPS.dual_lane_select && $past(STRAPS.dual_lane_select, 5)
      |-> LANE.lane_b_enable)
      else $error("lane b driver off in dual lane mode");
   chk_hold_cause: assert property ($rose(TRACK_HOLD) |->
      $past(SAMPLE_TRIGGER, 2) || $past(SAMPLE_TRIGGER, 3)
      || $past(SAMPLE_TRIGGER, 4))
      else $error("hold without trigger");
   chk_hold_span: assert property ($rose(TRACK_HOLD)
      |-> TRACK_HOLD [*3])
      else $error("conversion phase too short");
   chk_trig_taken: assert property (settled && awake
      && $past(awake, 5) && $rose(SAMPLE_TRIGGER) && !TRACK_HOLD
      |-> ##[1:4] TRACK_HOLD)
      else $error("trigger not taken in acquisition");
   chk_a_data_off: assert property (!LANE.lane_a_enable
      |-> !LANE.lane_a_out)
      else $error("lane a data without driver");
   chk_echo_copy: assert property (settled && awake
      && $past(awake, 8)
      |-> LANE.echo_clock_out == $past(SHIFT_CLOCK, 3))
      else $error("echo clock does not follow shift clock");
endmodule
bind adc_readout adc_readout_checker u_chk (.CLK(CLK), .RST(RST),
   .STRAPS(STRAPS), .SAMPLE_TRIGGER(SAMPLE_TRIGGER),
   .SAMPLE_LEVEL(SAMPLE_LEVEL), .TRACK_HOLD(TRACK_HOLD),
   .SHIFT_CLOCK(SHIFT_CLOCK), .LANE(LANE));
`default_nettype wire

// ---- testbench/host_model.sv ----
// host side: makes shift clock frames and gathers lane bits into words
// assumes go rises only once the result of a conversion is ready
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input  wire logic           go,
   input  wire logic           dual,
   input  wire adc_pkg::lane_s lane,
   output logic                sclk,
   output logic [15:0]         word,
   output logic                done
);
   int n;
   initial begin
      sclk = 1'h0;
      word = 16'h0000;
      done = 1'h0;
   end
   // clock stands low between frames; bits sampled before each fall
   always @(posedge go) begin
      done = 1'h0;
      #400;
      for (n = 0; n < (dual ? 8 : 16); n++) begin
         sclk = 1'h1;
         #160;
         word = dual ? {word[13:0], lane.lane_a_out, lane.lane_b_out}
                     : {word[14:0], lane.lane_a_out};
         sclk = 1'h0;
         #160;
      end
      done = 1'h1;
   end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for adc_readout with a host model on the lanes
// assumes the host model owns the shift clock
`timescale 1ns/10ps
`default_nettype none
module tb;
   import adc_pkg::*;
   logic        clk = 1'h0;
   logic        rst = 1'h1;
   strap_s      straps = 3'h4;
   logic        trig = 1'h0;
   logic [15:0] level = 16'h0000;
   logic        go = 1'h0;
   logic        track_hold;
   logic        sclk;
   lane_s       lane;
   logic [15:0] word;
   logic        done;
   logic [15:0] exp_q[$];
   int          mismatches = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          i;
   int          k;
   always #20 clk = ~clk;
   adc_readout DUT (.CLK(clk), .RST(rst), .STRAPS(straps),
      .SAMPLE_TRIGGER(trig), .SAMPLE_LEVEL(level),
      .TRACK_HOLD(track_hold), .SHIFT_CLOCK(sclk), .LANE(lane));
   host_model u_host (.go(go), .dual(straps.dual_lane_select),
      .lane(lane), .sclk(sclk), .word(word), .done(done));
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // reference: two's complement is offset binary with msb inverted
   task automatic convert(input logic [15:0] lvl);
      level = lvl;
      exp_q.push_back(straps.fixed_output_select ? TEST_PATTERN_DEF
                      : {~lvl[15], lvl[14:0]});
      repeat (3) @(negedge clk);
      trig = 1'h1;
      repeat (6) @(negedge clk);
      trig = 1'h0;
      repeat (6) @(negedge clk);
   endtask
   task automatic read_word();
      go = 1'h1;
      @(negedge clk);
      for (k = 0; k < 400 && done !== 1'h1; k++)
         @(negedge clk);
      check({15'h0000, done}, 16'h0001);
      go = 1'h0;
      @(negedge clk);
      check(word, exp_q.pop_front());
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      void'($urandom(32'hAC314769));
      repeat (3) @(negedge clk);
      rst = 1'h0;
      repeat (8) @(negedge clk);
      for (i = 0; i < 8; i++) begin
         straps = {1'h1, i[1], i[0]};
         repeat (8) @(negedge clk);
         convert(i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : 16'($urandom()));
         read_word();
      end
      $display("lane and pattern modes done");
      straps = 3'h4;
      repeat (8) @(negedge clk);
      for (i = 0; i < 19; i++)
         convert(16'($urandom()));
      check({15'h0000, track_hold}, 16'h0001);
      void'(exp_q.pop_back());
      for (i = 0; i < 18; i++) begin
         repeat ($urandom_range(0, 20)) @(negedge clk);
         read_word();
      end
      exp_q.push_back(16'h0000);
      read_word();
      $display("buffer fill and drain done");
      straps = 3'h0;
      repeat (8) @(negedge clk);
      trig = 1'h1;
      repeat (6) @(negedge clk);
      check({15'h0000, track_hold}, 16'h0000);
      check({11'h000, lane}, 16'h0000);
      trig = 1'h0;
      $display("sleep done");
      close_out();
   end
endmodule
`default_nettype wire
